// *** include/hsrt_regs.svh ***
// Register map, field positions and reset values of the receive tuning bank.
// Assumes an AXI4-Lite slave with 32-bit data and word-aligned registers.
`ifndef HSRT_REGS_SVH
`define HSRT_REGS_SVH

// ==========================================
// Register indices (byte address is index times four)
`define HSRT_IDX_PWR 6'h01
`define HSRT_IDX_CTRL 6'h03
`define HSRT_IDX_TUNE 6'h04
`define HSRT_IDX_STAT 6'h08

// ==========================================
// Reset values and writable masks
`define HSRT_RST_PWR 16'h0000
`define HSRT_RST_CTRL 16'hA444
`define HSRT_RST_TUNE 16'hB820
`define HSRT_MASK_PWR 16'h8000
`define HSRT_MASK_FULL 16'hFFFF

// ==========================================
// Field positions (least significant bit of each field)
`define HSRT_PWR_GLOBAL_PD 15
`define HSRT_CTL_SWING_LSB 12
`define HSRT_CTL_GAIN_LSB 6
`define HSRT_CTL_CAL_LSB 4
`define HSRT_CTL_UNSCR 3
`define HSRT_CTL_RX_EN 2
`define HSRT_CTL_RATE_LSB 0
`define HSRT_TUN_TRACK 15
`define HSRT_TUN_EQPRE_LSB 12
`define HSRT_TUN_ORDER_LSB 10
`define HSRT_TUN_VOTE_LSB 8
`define HSRT_TUN_EQLIM 7
`define HSRT_TUN_EQHLD 6
`define HSRT_TUN_LOCKTAP 5
`define HSRT_TUN_CRF_LSB 0

// ==========================================
// Field codes
`define HSRT_GAIN_FREEZE_ONCE 2'b00
`define HSRT_GAIN_FREEZE_LOCK 2'b01
`define HSRT_GAIN_FORCE_OFF 2'b10
`define HSRT_GAIN_FORCE_ON 2'b11
`define HSRT_CAL_AUTO 2'b00
`define HSRT_CAL_OFF 2'b01
`define HSRT_CAL_FORCE_UPD 2'b10
`define HSRT_CAL_FORCE_HOLD 2'b11
`define HSRT_EQPRE_DISABLE 3'b111
`define HSRT_VOTE_BASE 6'h04

// ==========================================
// Bus responses
`define HSRT_RESP_OKAY 2'b00
`define HSRT_RESP_SLVERR 2'b10

`endif

// *** include/hsrt_pkg.sv ***
// Types shared by the receive tuning bank: decode and state enums, control bundle.
// Assumes hsrt_regs.svh carries all numeric constants.
package hsrt_pkg;

	// ==========================================
	// Write channel state
	typedef enum logic [1:0] {
		HSRT_WR_COLLECT = 2'b01,
		HSRT_WR_RESP = 2'b10
	} hsrt_wr_state_t;

	// ==========================================
	// Register select, one-hot
	typedef enum logic [4:0] {
		HSRT_SEL_NONE = 5'b00001,
		HSRT_SEL_PWR = 5'b00010,
		HSRT_SEL_CTRL = 5'b00100,
		HSRT_SEL_TUNE = 5'b01000,
		HSRT_SEL_STAT = 5'b10000
	} hsrt_sel_t;

	// ==========================================
	// Control bundle driven toward the analog receive and transmit paths
	typedef struct packed {
		logic rx_active;
		logic atten_force_off;
		logic atten_force_on;
		logic atten_freeze;
		logic cal_start;
		logic cal_disable;
		logic cal_force;
		logic cal_auto_update;
		logic rx_unscrambled_use_en;
		logic [1:0] fast_rx_rate_sel;
		logic [3:0] fast_tx_swing_code;
		logic rx_converter_track_force;
		logic [2:0] rx_precursor_eq_sel;
		logic eq_disable;
		logic [1:0] recovery_order_sel;
		logic [5:0] recovery_vote_count;
		logic eq_tap_limit;
		logic eq_adapt_hold;
		logic recovery_lock_tap_sel;
		logic [4:0] tx_cursor_reduction;
	} hsrt_rx_ctl_t;

endpackage

// *** src/hsrt_rx_tuning_regs.sv ***
// Receive tuning register bank for one fast transceiver channel, AXI4-Lite slave.
// Assumes one 40 MHz clock; the power-down pin and gain lock come from outside
// the clock domain and are synchronised here.
//
// The AXI4-Lite slave port was decided locally.
`include "hsrt_regs.svh"

module hsrt_rx_tuning_regs (
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Channel pins and analog status
	input wire logic channel_powerdown_n,
	input wire logic agc_lock,
	// Decoded controls
	output hsrt_pkg::hsrt_rx_ctl_t rx_ctl
);

	// ==========================================
	// Address decode
	// Shared by both channels so reads and writes see the same map
	function automatic hsrt_pkg::hsrt_sel_t decode_sel(input logic [7:0] addr);
		hsrt_pkg::hsrt_sel_t sel;
		sel = hsrt_pkg::HSRT_SEL_NONE;
		if (addr[7:2] == `HSRT_IDX_PWR)
		begin
			sel = hsrt_pkg::HSRT_SEL_PWR;
		end
		else if (addr[7:2] == `HSRT_IDX_CTRL)
		begin
			sel = hsrt_pkg::HSRT_SEL_CTRL;
		end
		else if (addr[7:2] == `HSRT_IDX_TUNE)
		begin
			sel = hsrt_pkg::HSRT_SEL_TUNE;
		end
		else if (addr[7:2] == `HSRT_IDX_STAT)
		begin
			sel = hsrt_pkg::HSRT_SEL_STAT;
		end
		return sel;
	endfunction

	// ==========================================
	// Storage: index 0 power, 1 control, 2 tuning
	localparam logic [15:0] RST_VAL [0:2] = '{`HSRT_RST_PWR, `HSRT_RST_CTRL, `HSRT_RST_TUNE};
	localparam logic [15:0] WR_MASK [0:2] = '{`HSRT_MASK_PWR, `HSRT_MASK_FULL, `HSRT_MASK_FULL};
	logic [15:0] rf_r [0:2];
	logic [15:0] rf_nxt [0:2];
	// ==========================================
	// Write channel state
	hsrt_pkg::hsrt_wr_state_t wr_state_r;
	logic aw_held_r;
	logic w_held_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	// Read channel state
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	// Synchronisers and receive state
	logic pd_n_meta_r;
	logic pd_n_sync_r;
	logic lock_meta_r;
	logic lock_sync_r;
	logic rx_active_q_r;
	logic locked_once_r;
	hsrt_pkg::hsrt_rx_ctl_t ctl_r;
	hsrt_pkg::hsrt_rx_ctl_t ctl_nxt;
	// ==========================================
	// Handshake and decode wires
	wire aw_take = s_axi_awvalid && awready_r;
	wire w_take = s_axi_wvalid && wready_r;
	wire wr_fire = (wr_state_r == hsrt_pkg::HSRT_WR_COLLECT) && aw_held_r && w_held_r;
	wire b_done = bvalid_r && s_axi_bready;
	wire ar_take = s_axi_arvalid && arready_r;
	wire r_done = rvalid_r && s_axi_rready;
	wire hsrt_pkg::hsrt_sel_t wr_sel = decode_sel(awaddr_r);
	wire hsrt_pkg::hsrt_sel_t rd_sel = decode_sel(s_axi_araddr);
	wire [2:0] wr_hit = {wr_sel == hsrt_pkg::HSRT_SEL_TUNE,
		wr_sel == hsrt_pkg::HSRT_SEL_CTRL, wr_sel == hsrt_pkg::HSRT_SEL_PWR};
	// Status is read-only, so a write to it counts as unmapped
	wire wr_err = (wr_hit == 3'b000);
	wire rd_err = (rd_sel == hsrt_pkg::HSRT_SEL_NONE);

	// ==========================================
	// Field views
	wire [15:0] pwr_reg = rf_r[0];
	wire [15:0] ctrl_reg = rf_r[1];
	wire [15:0] tune_reg = rf_r[2];
	wire global_pd = pwr_reg[`HSRT_PWR_GLOBAL_PD];
	wire [1:0] gain_mode = ctrl_reg[`HSRT_CTL_GAIN_LSB +: 2];
	wire [1:0] cal_mode = ctrl_reg[`HSRT_CTL_CAL_LSB +: 2];
	wire rx_active = ctrl_reg[`HSRT_CTL_RX_EN] && pd_n_sync_r && !global_pd;
	wire [15:0] stat_reg = {11'h000, pd_n_sync_r, locked_once_r, lock_sync_r,
		global_pd, rx_active_q_r};

	// ==========================================
	// Byte-lane merge of each register; only the two low lanes exist
	genvar gj;
	genvar gi;
	generate
		for (gj = 0; gj < 3; gj++)
		begin : g_reg
			for (gi = 0; gi < 2; gi++)
			begin : g_lane
				assign rf_nxt[gj][8*gi +: 8] = (wr_fire && wr_hit[gj] && wstrb_r[gi]) ?
					((wdata_r[8*gi +: 8] & WR_MASK[gj][8*gi +: 8])
					| (rf_r[gj][8*gi +: 8] & ~WR_MASK[gj][8*gi +: 8]))
					: rf_r[gj][8*gi +: 8];
			end
		end
	endgenerate

	// ==========================================
	// Read data selection; upper half always reads zero
	// plain read mux
	wire [15:0] rd_word = (rd_sel == hsrt_pkg::HSRT_SEL_PWR) ? pwr_reg :
		(rd_sel == hsrt_pkg::HSRT_SEL_CTRL) ? ctrl_reg :
		(rd_sel == hsrt_pkg::HSRT_SEL_TUNE) ? tune_reg :
		(rd_sel == hsrt_pkg::HSRT_SEL_STAT) ? stat_reg : 16'h0000;

	// ==========================================
	// Register storage
	// reset values
	always_ff @(posedge aclk)
	begin
		for (int k = 0; k < 3; k++)
		begin
			rf_r[k] <= aresetn ? rf_nxt[k] : RST_VAL[k];
		end
	end

	// ==========================================
	// Write address and data capture; taken in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end
		else
		begin
			if (aw_take)
			begin
				aw_held_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			else if (wr_fire)
			begin
				aw_held_r <= 1'b0;
			end
			if (w_take)
			begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			else if (wr_fire)
			begin
				w_held_r <= 1'b0;
			end
		end
	end

	// ==========================================
	// Write response machine; ready drops once a beat is held, so one write at a time
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_state_r <= hsrt_pkg::HSRT_WR_COLLECT;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= `HSRT_RESP_OKAY;
		end
		else
		begin
			unique case (wr_state_r)
				hsrt_pkg::HSRT_WR_COLLECT:
				begin
					if (aw_take)
					begin
						awready_r <= 1'b0;
					end
					if (w_take)
					begin
						wready_r <= 1'b0;
					end
					if (wr_fire)
					begin
						bvalid_r <= 1'b1;
						bresp_r <= wr_err ? `HSRT_RESP_SLVERR : `HSRT_RESP_OKAY;
						wr_state_r <= hsrt_pkg::HSRT_WR_RESP;
					end
				end
				hsrt_pkg::HSRT_WR_RESP:
				begin
					if (b_done)
					begin
						bvalid_r <= 1'b0;
						awready_r <= 1'b1;
						wready_r <= 1'b1;
						wr_state_r <= hsrt_pkg::HSRT_WR_COLLECT;
					end
				end
			endcase
		end
	end

	// ==========================================
	// Read channel; data latched at the address beat
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `HSRT_RESP_OKAY;
		end
		else if (ar_take)
		begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= {16'h0000, rd_word};
			rresp_r <= rd_err ? `HSRT_RESP_SLVERR : `HSRT_RESP_OKAY;
		end
		else if (r_done)
		begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	// ==========================================
	// Two-stage synchronisers for the pin and the analog lock flag
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pd_n_meta_r <= 1'b0;
			pd_n_sync_r <= 1'b0;
			lock_meta_r <= 1'b0;
			lock_sync_r <= 1'b0;
		end
		else
		begin
			pd_n_meta_r <= channel_powerdown_n;
			pd_n_sync_r <= pd_n_meta_r;
			lock_meta_r <= agc_lock;
			lock_sync_r <= lock_meta_r;
		end
	end

	// ==========================================
	// Receive state: enable history and first-lock memory
	// Lock memory is dropped when the receiver stops or the mode leaves 00,
	// so a fresh enable starts adapting again unless the synchronised lock flag is still high
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_active_q_r <= 1'b0;
			locked_once_r <= 1'b0;
		end
		else
		begin
			rx_active_q_r <= rx_active;
			locked_once_r <= rx_active && (gain_mode == `HSRT_GAIN_FREEZE_ONCE)
				&& (lock_sync_r || locked_once_r);
		end
	end

	// ==========================================
	// Control decode toward the analog paths
	always_comb
	begin
		ctl_nxt = '0;
		ctl_nxt.rx_active = rx_active;
		ctl_nxt.atten_freeze = ((gain_mode == `HSRT_GAIN_FREEZE_ONCE)
			&& (locked_once_r || lock_sync_r))
			|| ((gain_mode == `HSRT_GAIN_FREEZE_LOCK) && lock_sync_r);
		ctl_nxt.atten_force_off = (gain_mode == `HSRT_GAIN_FORCE_OFF);
		ctl_nxt.atten_force_on = (gain_mode == `HSRT_GAIN_FORCE_ON);
		ctl_nxt.cal_start = rx_active && !rx_active_q_r && (cal_mode == `HSRT_CAL_AUTO);
		ctl_nxt.cal_disable = (cal_mode == `HSRT_CAL_OFF);
		ctl_nxt.cal_force = (cal_mode == `HSRT_CAL_FORCE_UPD)
			|| (cal_mode == `HSRT_CAL_FORCE_HOLD);
		ctl_nxt.cal_auto_update = (cal_mode == `HSRT_CAL_FORCE_UPD);
		ctl_nxt.rx_unscrambled_use_en = ctrl_reg[`HSRT_CTL_UNSCR];
		ctl_nxt.fast_rx_rate_sel = ctrl_reg[`HSRT_CTL_RATE_LSB +: 2];
		ctl_nxt.fast_tx_swing_code = ctrl_reg[`HSRT_CTL_SWING_LSB +: 4];
		ctl_nxt.rx_converter_track_force = tune_reg[`HSRT_TUN_TRACK];
		ctl_nxt.rx_precursor_eq_sel = tune_reg[`HSRT_TUN_EQPRE_LSB +: 3];
		ctl_nxt.eq_disable = (tune_reg[`HSRT_TUN_EQPRE_LSB +: 3] == `HSRT_EQPRE_DISABLE);
		// recovery order, reserved code passed as written
		ctl_nxt.recovery_order_sel = tune_reg[`HSRT_TUN_ORDER_LSB +: 2];
		// vote count is four doubled per code step
		ctl_nxt.recovery_vote_count = `HSRT_VOTE_BASE << tune_reg[`HSRT_TUN_VOTE_LSB +: 2];
		ctl_nxt.eq_tap_limit = tune_reg[`HSRT_TUN_EQLIM];
		ctl_nxt.eq_adapt_hold = tune_reg[`HSRT_TUN_EQHLD];
		ctl_nxt.recovery_lock_tap_sel = tune_reg[`HSRT_TUN_LOCKTAP];
		ctl_nxt.tx_cursor_reduction = tune_reg[`HSRT_TUN_CRF_LSB +: 5];
	end
	// Registered so the analog side sees clean levels one cycle after a change
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctl_r <= '0;
		end
		else
		begin
			ctl_r <= ctl_nxt;
		end
	end

	// ==========================================
	// Outputs, each from a flip-flop
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign rx_ctl = ctl_r;
endmodule // hsrt_rx_tuning_regs

// *** verif/hsrt_rx_tuning_regs_asserts.sv ***
// Checker for the receive tuning bank: bus answers and control decodes.
// Assumes it is bound to the top module and sees only its ports.
module hsrt_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic channel_powerdown_n,
	input wire hsrt_pkg::hsrt_rx_ctl_t rx_ctl
);
	// ==========================================
	// Clocking and transfer sequences
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// write answered after the commit cycle
	a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
		else $error("write response not two cycles after take");
	a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data not one cycle after take");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	a_atten_excl: assert property ($past(aresetn) |->
		$onehot0({rx_ctl.atten_force_off, rx_ctl.atten_force_on, rx_ctl.atten_freeze}))
		else $error("attenuator controls overlap");
	a_eq_disable: assert property (rx_ctl.eq_disable == (rx_ctl.rx_precursor_eq_sel == 3'h7))
		else $error("equalizer disable decode wrong");
	a_vote_count: assert property ($past(aresetn) |->
		rx_ctl.recovery_vote_count inside {6'h04, 6'h08, 6'h10, 6'h20})
		else $error("vote threshold out of set");
	a_cal_mode: assert property (rx_ctl.cal_auto_update |-> rx_ctl.cal_force && !rx_ctl.cal_disable)
		else $error("calibration mode decode wrong");
	a_cal_oneshot: assert property (rx_ctl.cal_start |=> !rx_ctl.cal_start)
		else $error("calibration start longer than one cycle");
	a_pd_rx_off: assert property (!channel_powerdown_n [*4] |-> !rx_ctl.rx_active)
		else $error("receiver active while pin powered down");
endmodule // hsrt_chk

bind hsrt_rx_tuning_regs hsrt_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rdata, .channel_powerdown_n, .rx_ctl);

// *** verif/tb.sv ***
// Self-checking bench for the receive tuning bank with a register model.
// Assumes the bank answers AXI4-Lite at byte addresses four times the index.
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================
	// Stimulus and observed signals
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic channel_powerdown_n = 1'b1, agc_lock = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	hsrt_pkg::hsrt_rx_ctl_t rx_ctl;
	int mismatches = 0, comparisons = 0, seed = 32'h67b2, pulses = 0;
	logic [15:0] cm = 16'ha444, tm = 16'hb820, pm = 16'h0000, v;

	always #12.5 aclk = ~aclk;
	// Count cycles with the calibration start high
	always @(negedge aclk) if (rx_ctl.cal_start === 1'b1) pulses++;

	hsrt_rx_tuning_regs DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .channel_powerdown_n, .agc_lock, .rx_ctl);

	// ==========================================
	// Model of the decoded controls
	function automatic hsrt_pkg::hsrt_rx_ctl_t ex(logic lk, logic once);
		hsrt_pkg::hsrt_rx_ctl_t e;
		e = '0;
		e.rx_active = cm[2] & channel_powerdown_n & ~pm[15];
		e.atten_freeze = (cm[7:6] == 2'h1) ? lk : (cm[7:6] == 2'h0) & (lk | once);
		e.atten_force_off = cm[7:6] == 2'h2;
		e.atten_force_on = cm[7:6] == 2'h3;
		e.cal_disable = cm[5:4] == 2'h1;
		e.cal_force = cm[5];
		e.cal_auto_update = cm[5:4] == 2'h2;
		e.rx_unscrambled_use_en = cm[3];
		e.fast_rx_rate_sel = cm[1:0];
		e.fast_tx_swing_code = cm[15:12];
		e.rx_converter_track_force = tm[15];
		e.rx_precursor_eq_sel = tm[14:12];
		e.eq_disable = tm[14:12] == 3'h7;
		e.recovery_order_sel = tm[11:10];
		e.recovery_vote_count = 6'h04 << tm[9:8];
		e.eq_tap_limit = tm[7];
		e.eq_adapt_hold = tm[6];
		e.recovery_lock_tap_sel = tm[5];
		e.tx_cursor_reduction = tm[4:0];
		return e;
	endfunction

	// ==========================================
	// Compare and closing tasks
	task automatic chk(logic [31:0] g, logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			mismatches++;
			$display("Error %0t: value %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_ctl(hsrt_pkg::hsrt_rx_ctl_t g, hsrt_pkg::hsrt_rx_ctl_t e);
		comparisons++;
		if (g !== e)
		begin
			mismatches++;
			$display("Error %0t: controls %h expected %h", $time, g, e);
		end
	endtask
	task automatic stop_test;
		if (mismatches == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Lets synchronisers and the control register catch up
	task automatic settle;
		repeat (5) @(posedge aclk);
		@(negedge aclk);
	endtask

	// ==========================================
	// Bus tasks; state is sampled at the falling edge so it matches the next rising edge
	task automatic wr(logic [7:0] a, logic [15:0] d, logic [3:0] s);
		logic at, wt, bt;
		logic [1:0] r, er;
		int i;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(negedge aclk);
			at = s_axi_awready;
			wt = s_axi_wready;
			bt = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (at) s_axi_awvalid <= 1'b0;
			if (wt) s_axi_wvalid <= 1'b0;
			if (bt) break;
		end
		s_axi_bready <= 1'b0;
		if (i == 50)
		begin
			mismatches++;
			stop_test();
		end
		er = 2'h0;
		case (a[7:2])
			6'h01: if (s[1]) pm[15] = d[15];
			6'h03: cm = {s[1] ? d[15:8] : cm[15:8], s[0] ? d[7:0] : cm[7:0]};
			6'h04: tm = {s[1] ? d[15:8] : tm[15:8], s[0] ? d[7:0] : tm[7:0]};
			default: er = 2'h2;
		endcase
		chk({30'h0000_0000, r}, {30'h0000_0000, er});
	endtask
	task automatic rdc(logic [7:0] a);
		logic t, rt;
		logic [31:0] d, e;
		logic [1:0] r, er;
		int i;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(negedge aclk);
			t = s_axi_arready;
			rt = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (t) s_axi_arvalid <= 1'b0;
			if (rt) break;
		end
		s_axi_rready <= 1'b0;
		if (i == 50)
		begin
			mismatches++;
			stop_test();
		end
		er = 2'h0;
		case (a[7:2])
			6'h01: e = {16'h0000, pm};
			6'h03: e = {16'h0000, cm};
			6'h04: e = {16'h0000, tm};
			// Status assumes the lock input has stayed low
			6'h08: e = {27'h000_0000, channel_powerdown_n, 2'b00, pm[15],
				cm[2] & channel_powerdown_n & ~pm[15]};
			default: {e, er} = {32'h0000_0000, 2'h2};
		endcase
		chk(d, e);
		chk({30'h0000_0000, r}, {30'h0000_0000, er});
	endtask

	// ==========================================
	// Main sequence
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(8'h0c);
		rdc(8'h10);
		rdc(8'h04);
		settle;
		chk_ctl(rx_ctl, ex(1'b0, 1'b0));
		for (int k = 0; k < 32; k++)
		begin
			v = 16'($random(seed));
			wr(8'h0c, v, 4'h3);
			v = 16'($random(seed));
			wr(8'h10, v, 4'h3);
			rdc(8'h0c);
			rdc(8'h10);
			settle;
			chk_ctl(rx_ctl, ex(1'b0, 1'b0));
		end
		// Gain loop 00 keeps the freeze after lock is lost, 01 follows lock
		wr(8'h0c, 16'h0004, 4'h3);
		@(posedge aclk);
		agc_lock <= 1'b1;
		settle;
		chk_ctl(rx_ctl, ex(1'b1, 1'b1));
		@(posedge aclk);
		agc_lock <= 1'b0;
		settle;
		chk_ctl(rx_ctl, ex(1'b0, 1'b1));
		wr(8'h0c, 16'h0044, 4'h3);
		@(posedge aclk);
		agc_lock <= 1'b1;
		settle;
		chk_ctl(rx_ctl, ex(1'b1, 1'b0));
		@(posedge aclk);
		agc_lock <= 1'b0;
		// Code 01 lets the attenuator move again once lock is lost
		settle;
		chk_ctl(rx_ctl, ex(1'b0, 1'b0));
		// Calibration start only for code 00 on receiver enable
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h0c, {10'h000, 2'(k), 4'h0}, 4'h3);
			pulses = 0;
			wr(8'h0c, {10'h000, 2'(k), 4'h4}, 4'h3);
			settle;
			chk(32'(pulses), (k == 0) ? 32'h0000_0001 : 32'h0000_0000);
		end
		// Global power-down and the pin each turn the receiver off
		wr(8'h04, 16'hffff, 4'h3);
		rdc(8'h04);
		settle;
		chk_ctl(rx_ctl, ex(1'b0, 1'b0));
		wr(8'h04, 16'h0000, 4'h3);
		@(posedge aclk);
		channel_powerdown_n <= 1'b0;
		settle;
		chk_ctl(rx_ctl, ex(1'b0, 1'b0));
		@(posedge aclk);
		channel_powerdown_n <= 1'b1;
		settle;
		chk_ctl(rx_ctl, ex(1'b0, 1'b0));
		// Byte lanes, unused lanes, status and unmapped places
		wr(8'h10, 16'h5a5a, 4'h1);
		rdc(8'h10);
		wr(8'h0c, 16'h1234, 4'h2);
		rdc(8'h0c);
		wr(8'h10, 16'hffff, 4'hc);
		rdc(8'h10);
		wr(8'h20, 16'hffff, 4'h3);
		wr(8'h3c, 16'hffff, 4'h3);
		rdc(8'h3c);
		rdc(8'h0c);
		rdc(8'h20);
		stop_test();
	end
endmodule // tb
